// file: common/user_ctrl_pkg.sv
// Summary of operation
// - Second select closure jumps to memory D in D-only mode
// - Leaving D delayed 1.5/3.5/5.5 s or none
// - Rocker modes: volume, memory select, mixed
// - Mixed mode classes presses short or long
// - Short/long boundary set by programmable threshold
// - Up closure raises gain, down lowers
// - Toggle high raises, low lowers one step
// - Step size 1 to 4 dB
// - Range 0 to 48 dB, clamped both ends
// - Volume loads programmable default at power-up
// - Disabled volume control ignores inputs
// - Each step beeps, up/down tone programmable
// - Limit request gives one limit-kind beep when enabled
// - Six memories, A always valid
// - One or two select lines, momentary/static, pull
// - Momentary: start A, next valid, wrap
// - Momentary active when mode momentary, with D-only off or two lines on
// - D-only momentary: high second line forces D
// - Presses ignored during power-on delay
package user_ctrl_pkg;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_VOL_CFG = 8'h04;
	localparam logic [7:0] ADDR_BEEP_CFG = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_TIMING = 8'h10;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0103;
	localparam logic [31:0] VOL_CFG_RST = 32'h0018_3000;
	localparam logic [31:0] BEEP_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] TIMING_RST = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ************************************************************
	// Encodings
	// ************************************************************
	typedef enum logic [1:0] {
		ROCK_VOLUME = 2'h0,
		ROCK_MEMORY = 2'h1,
		ROCK_MIXED = 2'h2
	} rocker_mode_t;
	typedef enum logic [1:0] {
		DB_OFF = 2'h0,
		DB_1P5 = 2'h1,
		DB_3P5 = 2'h2,
		DB_5P5 = 2'h3
	} debounce_t;
	localparam logic [2:0] MEM_A = 3'h0;
	localparam logic [2:0] MEM_B = 3'h1;
	localparam logic [2:0] MEM_C = 3'h2;
	localparam logic [2:0] MEM_D = 3'h3;
	localparam int NUM_MEM = 6;
	localparam logic [5:0] VOL_MAX_DB = 6'h30;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ = 20_000_000;
	localparam int DB_1P5_MS = 1500;
	localparam int DB_3P5_MS = 3500;
	localparam int DB_5P5_MS = 5500;
	localparam int MS_CYC = CLK_HZ / 1000;
	localparam int TICK_W = 32;
endpackage

// file: hdl/switch_sync.sv
`timescale 1ns/1ps
module switch_sync #(
	parameter int WIDTH = 4
) (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sync_state_t;
	sync_state_t st;
	sync_state_t next_st;
	always_comb begin
		next_st.s1 = i_async;
		next_st.s2 = st.s1;
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign o_sync = st.s2;
endmodule

// file: hdl/user_switch_program_volume_ctrl.sv
`timescale 1ns/1ps
module user_switch_program_volume_ctrl #(
	parameter int DB_1P5_CYC = user_ctrl_pkg::DB_1P5_MS * user_ctrl_pkg::MS_CYC,
	parameter int DB_3P5_CYC = user_ctrl_pkg::DB_3P5_MS * user_ctrl_pkg::MS_CYC,
	parameter int DB_5P5_CYC = user_ctrl_pkg::DB_5P5_MS * user_ctrl_pkg::MS_CYC,
	parameter int POR_UNIT_CYC = user_ctrl_pkg::MS_CYC,
	parameter int LONG_UNIT_CYC = user_ctrl_pkg::MS_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_program_select_line,
	input wire logic i_second_program_select_line,
	input wire logic i_volume_up_input,
	input wire logic i_volume_down_input,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [5:0] o_volume_db,
	output logic [2:0] o_memory,
	output logic o_mem_change,
	output logic [2:0] o_mem_change_idx,
	output logic o_beep_req,
	output logic [1:0] o_beep_kind,
	output logic [3:0] o_beep_tone,
	output logic [3:0] o_beep_level,
	output logic o_audio_enable,
	output logic o_ms_pull_up,
	output logic o_ms2_pull_up
);
	// ************************************************************
	// State
	// ************************************************************
	localparam int TICK_W = user_ctrl_pkg::TICK_W;
	typedef struct packed {
		logic aw_rdy;
		logic w_rdy;
		logic ar_rdy;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] ctrl;
		logic [31:0] vol_cfg;
		logic [31:0] beep_cfg;
		logic [31:0] timing;
		logic [5:0] vol;
		logic [2:0] mem;
		logic [2:0] last_mem;
		logic mem_chg;
		logic beep;
		logic [1:0] beep_kind;
		logic [3:0] beep_tone;
		logic [3:0] beep_level;
		logic [3:0] prev_in;
		logic [TICK_W-1:0] por_cnt;
		logic por_done;
		logic [TICK_W-1:0] press_cnt;
		logic [TICK_W-1:0] db_cnt;
		logic db_pend;
		logic init;
	} state_t;
	state_t st;
	state_t next_st;
	logic [3:0] sw;
	switch_sync #(
		.WIDTH(4)
	) u_sync (
		.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n),
		.i_async({i_volume_down_input, i_volume_up_input,
			i_second_program_select_line, i_program_select_line}),
		.o_sync(sw)
	);
	// ************************************************************
	// Configuration fields
	// ************************************************************
	logic vc_en;
	logic up_beep_en;
	logic lim_beep_en;
	logic toggle_vc;
	user_ctrl_pkg::rocker_mode_t rmode;
	logic mixed_short_mem;
	logic ms_static;
	logic d_only;
	logic ms_pol;
	logic ms2_pol;
	logic two_lines;
	user_ctrl_pkg::debounce_t db_sel;
	logic [5:0] valid_mem;
	logic [2:0] step_db;
	logic [5:0] vol_min;
	logic [5:0] vol_max;
	logic [5:0] vol_def;
	logic [15:0] por_units;
	logic [15:0] long_units;
	always_comb begin
		vc_en = st.ctrl[0];
		up_beep_en = st.ctrl[1];
		lim_beep_en = st.ctrl[2];
		toggle_vc = st.ctrl[3];
		rmode = user_ctrl_pkg::rocker_mode_t'(st.ctrl[5:4]);
		mixed_short_mem = st.ctrl[6];
		ms_static = st.ctrl[7];
		d_only = st.ctrl[8];
		ms_pol = st.ctrl[9];
		ms2_pol = st.ctrl[10];
		two_lines = st.ctrl[11];
		db_sel = user_ctrl_pkg::debounce_t'(st.ctrl[13:12]);
		valid_mem = {st.ctrl[20:16], 1'b1};
		step_db = {1'b0, st.vol_cfg[1:0]} + 3'h1;
		vol_min = st.vol_cfg[13:8];
		vol_max = (st.vol_cfg[21:16] > user_ctrl_pkg::VOL_MAX_DB) ?
			user_ctrl_pkg::VOL_MAX_DB : st.vol_cfg[21:16];
		vol_def = st.vol_cfg[29:24];
		por_units = st.timing[15:0];
		long_units = st.timing[31:16];
	end
	// Next valid memory after cur, wrapping to A, skipping D if asked
	function automatic logic [2:0] next_mem(input logic [2:0] cur,
		input logic [5:0] vm, input logic skip_d);
		logic [2:0] r;
		logic found;
		r = user_ctrl_pkg::MEM_A;
		found = 1'b0;
		for (int i = 1; i < user_ctrl_pkg::NUM_MEM; i++) begin
			if (!found && i > int'(cur) && vm[i] &&
				!(skip_d && i == int'(user_ctrl_pkg::MEM_D))) begin
				r = 3'(i);
				found = 1'b1;
			end
		end
		return r;
	endfunction
	function automatic logic [2:0] valid_or_a(input logic [2:0] m,
		input logic [5:0] vm);
		return vm[m] ? m : user_ctrl_pkg::MEM_A;
	endfunction
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		for (int i = 0; i < 4; i++) begin
			r[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
		end
		return r;
	endfunction
	// ************************************************************
	// Next state
	// ************************************************************
	logic ms;
	logic ms2;
	logic up;
	logic dn;
	logic ms_rise;
	logic up_rise;
	logic up_fall;
	logic dn_rise;
	logic dn_fall;
	logic vol_step_up;
	logic vol_step_dn;
	logic mem_step;
	logic [2:0] target;
	logic [TICK_W-1:0] db_len;
	logic d_hold;
	logic [6:0] vsum;
	logic wr_do;
	always_comb begin
		next_st = st;
		next_st.mem_chg = 1'b0;
		next_st.beep = 1'b0;
		ms = sw[0] ^ ms_pol;
		ms2 = sw[1] ^ ms2_pol;
		up = sw[2];
		dn = sw[3];
		next_st.prev_in = {dn, up, ms2, ms};
		ms_rise = ms && !st.prev_in[0];
		up_rise = up && !st.prev_in[2];
		up_fall = !up && st.prev_in[2];
		dn_rise = dn && !st.prev_in[3];
		dn_fall = !dn && st.prev_in[3];
		// Power-on delay
		if (!st.por_done) begin
			if (st.por_cnt >= TICK_W'(por_units) * TICK_W'(POR_UNIT_CYC)) begin
				next_st.por_done = 1'b1;
			end else begin
				next_st.por_cnt = st.por_cnt + 1'b1;
			end
		end
		// Rocker press classification
		vol_step_up = 1'b0;
		vol_step_dn = 1'b0;
		mem_step = 1'b0;
		if (up || dn) begin
			next_st.press_cnt = (&st.press_cnt) ? st.press_cnt :
				st.press_cnt + 1'b1;
		end else begin
			next_st.press_cnt = '0;
		end
		if (st.por_done) begin
			if (toggle_vc) begin
				vol_step_up = up_rise;
				vol_step_dn = up_fall;
			end else if (rmode == user_ctrl_pkg::ROCK_VOLUME) begin
				vol_step_up = up_rise;
				vol_step_dn = dn_rise;
			end else if (rmode == user_ctrl_pkg::ROCK_MEMORY) begin
				mem_step = up_rise || dn_rise;
			end else if (up_fall || dn_fall) begin
				// Classify at release
				if ((st.press_cnt >= TICK_W'(long_units) *
					TICK_W'(LONG_UNIT_CYC)) == mixed_short_mem) begin
					vol_step_up = up_fall;
					vol_step_dn = dn_fall;
				end else begin
					mem_step = 1'b1;
				end
			end
		end
		// Volume stepping
		vsum = {1'b0, st.vol} + {4'h0, step_db};
		if (vc_en && (vol_step_up || vol_step_dn)) begin
			next_st.beep_kind = vol_step_up ? 2'h0 : 2'h1;
			next_st.beep_tone = vol_step_up ? st.beep_cfg[3:0] :
				st.beep_cfg[11:8];
			next_st.beep_level = vol_step_up ? st.beep_cfg[7:4] :
				st.beep_cfg[15:12];
			next_st.beep = up_beep_en;
			if (vol_step_up && st.vol >= vol_max) begin
				next_st.beep = lim_beep_en;
				next_st.beep_kind = 2'h2;
				next_st.beep_tone = st.beep_cfg[19:16];
				next_st.beep_level = st.beep_cfg[23:20];
			end else if (vol_step_dn && st.vol <= vol_min) begin
				next_st.beep = lim_beep_en;
				next_st.beep_kind = 2'h2;
				next_st.beep_tone = st.beep_cfg[19:16];
				next_st.beep_level = st.beep_cfg[23:20];
			end else if (vol_step_up) begin
				next_st.vol = (vsum > {1'b0, vol_max}) ? vol_max :
					vsum[5:0];
			end else begin
				next_st.vol = ({1'b0, st.vol} <
					{1'b0, vol_min} + {4'h0, step_db}) ?
					vol_min : st.vol - {3'h0, step_db};
			end
		end
		if (!st.por_done) begin
			next_st.vol = vol_def;
		end
		// Telecoil exit hold, shared by both D-only modes
		unique case (db_sel)
			user_ctrl_pkg::DB_OFF: db_len = '0;
			user_ctrl_pkg::DB_1P5: db_len = TICK_W'(DB_1P5_CYC);
			user_ctrl_pkg::DB_3P5: db_len = TICK_W'(DB_3P5_CYC);
			user_ctrl_pkg::DB_5P5: db_len = TICK_W'(DB_5P5_CYC);
		endcase
		d_hold = 1'b0;
		next_st.db_pend = 1'b0;
		// Reclosing or expiry clears the count
		next_st.db_cnt = '0;
		if (two_lines && d_only && !ms2 && st.mem == user_ctrl_pkg::MEM_D &&
			st.db_cnt < db_len) begin
			d_hold = 1'b1;
			next_st.db_cnt = st.db_cnt + 1'b1;
			next_st.db_pend = 1'b1;
		end
		// Memory selection
		if (two_lines && ms_static) begin
			if (d_only) begin
				target = ms2 ? user_ctrl_pkg::MEM_D :
					(d_hold ? st.mem :
					(ms ? valid_or_a(user_ctrl_pkg::MEM_B, valid_mem) :
					user_ctrl_pkg::MEM_A));
			end else begin
				target = valid_or_a({1'b0, ms2, ms}, valid_mem);
			end
		end else if (two_lines && d_only) begin
			target = st.mem;
			if (ms2) begin
				target = user_ctrl_pkg::MEM_D;
				if (st.mem != user_ctrl_pkg::MEM_D) begin
					next_st.last_mem = st.mem;
				end
			end else if (st.mem == user_ctrl_pkg::MEM_D) begin
				if (!d_hold) begin
					target = st.last_mem;
				end
			end else if ((ms_rise || mem_step) && st.por_done) begin
				target = next_mem(st.mem, valid_mem, 1'b1);
			end
		end else begin
			target = st.mem;
			if (!ms_static && !d_only && st.por_done &&
				(ms_rise || mem_step)) begin
				target = next_mem(st.mem, valid_mem, 1'b0);
			end else if (ms_static && !two_lines) begin
				target = ms ? valid_or_a(user_ctrl_pkg::MEM_B, valid_mem) :
					user_ctrl_pkg::MEM_A;
			end else if (mem_step && st.por_done) begin
				target = next_mem(st.mem, valid_mem, 1'b0);
			end
		end
		if (target != st.mem || st.init) begin
			next_st.mem = target;
			next_st.mem_chg = 1'b1;
		end
		next_st.init = 1'b0;
		// AXI4-Lite slave
		if (i_awvalid && st.aw_rdy) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = i_awaddr;
		end
		if (i_wvalid && st.w_rdy) begin
			next_st.w_got = 1'b1;
			next_st.wdata = i_wdata;
			next_st.wstrb = i_wstrb;
		end
		wr_do = st.aw_got && st.w_got && !st.bvalid;
		if (wr_do) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = user_ctrl_pkg::RESP_OKAY;
			unique case (st.awaddr)
				user_ctrl_pkg::ADDR_CTRL:
					next_st.ctrl = wmerge(st.ctrl, st.wdata, st.wstrb);
				user_ctrl_pkg::ADDR_VOL_CFG:
					next_st.vol_cfg = wmerge(st.vol_cfg, st.wdata, st.wstrb);
				user_ctrl_pkg::ADDR_BEEP_CFG:
					next_st.beep_cfg = wmerge(st.beep_cfg, st.wdata, st.wstrb);
				user_ctrl_pkg::ADDR_TIMING:
					next_st.timing = wmerge(st.timing, st.wdata, st.wstrb);
				user_ctrl_pkg::ADDR_STATUS: ;
				default: next_st.bresp = user_ctrl_pkg::RESP_SLVERR;
			endcase
		end
		if (st.bvalid && i_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (i_arvalid && st.ar_rdy) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = user_ctrl_pkg::RESP_OKAY;
			unique case (i_araddr)
				user_ctrl_pkg::ADDR_CTRL: next_st.rdata = st.ctrl;
				user_ctrl_pkg::ADDR_VOL_CFG: next_st.rdata = st.vol_cfg;
				user_ctrl_pkg::ADDR_BEEP_CFG: next_st.rdata = st.beep_cfg;
				user_ctrl_pkg::ADDR_TIMING: next_st.rdata = st.timing;
				user_ctrl_pkg::ADDR_STATUS: next_st.rdata = {19'h0,
					st.db_pend, st.por_done, st.mem, 2'h0, st.vol};
				default: begin
					next_st.rdata = '0;
					next_st.rresp = user_ctrl_pkg::RESP_SLVERR;
				end
			endcase
		end else if (st.rvalid && i_rready) begin
			next_st.rvalid = 1'b0;
		end
		next_st.aw_rdy = !next_st.aw_got && !next_st.bvalid;
		next_st.w_rdy = !next_st.w_got && !next_st.bvalid;
		next_st.ar_rdy = !next_st.rvalid;
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			st <= '0;
			st.ctrl <= user_ctrl_pkg::CTRL_RST;
			st.vol_cfg <= user_ctrl_pkg::VOL_CFG_RST;
			st.beep_cfg <= user_ctrl_pkg::BEEP_CFG_RST;
			st.timing <= user_ctrl_pkg::TIMING_RST;
			st.vol <= user_ctrl_pkg::VOL_CFG_RST[29:24];
			st.init <= 1'b1;
		end else begin
			st <= next_st;
		end
	end
	// ************************************************************
	// Outputs
	// ************************************************************
	assign o_awready = st.aw_rdy;
	assign o_wready = st.w_rdy;
	assign o_bvalid = st.bvalid;
	assign o_bresp = st.bresp;
	assign o_arready = st.ar_rdy;
	assign o_rvalid = st.rvalid;
	assign o_rdata = st.rdata;
	assign o_rresp = st.rresp;
	assign o_volume_db = st.vol;
	assign o_memory = st.mem;
	assign o_mem_change = st.mem_chg;
	assign o_mem_change_idx = st.mem;
	assign o_beep_req = st.beep;
	assign o_beep_kind = st.beep_kind;
	assign o_beep_tone = st.beep_tone;
	assign o_beep_level = st.beep_level;
	assign o_audio_enable = st.por_done;
	assign o_ms_pull_up = st.ctrl[9];
	assign o_ms2_pull_up = st.ctrl[10];
endmodule

// file: sim/switch_model.sv
`timescale 1ns/1ps
module switch_model (
	input wire logic i_core_clk,
	input wire logic i_ms_pull_up,
	input wire logic i_ms2_pull_up,
	output logic o_sel,
	output logic o_sel2,
	output logic o_up,
	output logic o_down
);
	logic [3:0] closed = 4'h0;
	// Open contact rests at the selected pull level
	assign o_sel = closed[0] ^ i_ms_pull_up;
	assign o_sel2 = closed[1] ^ i_ms2_pull_up;
	assign o_up = closed[2];
	assign o_down = closed[3];
	task automatic set(input int k, input logic v);
		@(posedge i_core_clk);
		closed[k] <= v;
		repeat (12) @(posedge i_core_clk);
	endtask
	task automatic press(input int k);
		set(k, 1'b1);
		set(k, 1'b0);
	endtask
endmodule

// file: sim/user_switch_program_volume_ctrl_bench.sv
`timescale 1ns/1ps
module user_switch_program_volume_ctrl_bench;
	logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, chg, beep_req;
	logic audio_en, ms_pu, ms2_pu, sel, sel2, up, down;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_val;
	logic [1:0] bresp, rresp, beep_kind, rd_resp, last_kind;
	logic [5:0] vol;
	logic [2:0] mem, chg_idx;
	logic [3:0] tone, level, last_tone, last_level, wstrb, ws;
	int fail_count = 0;
	int n_checks = 0;
	int nbeep = 0;
	logic [7:0] reg_addr [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20};
	logic [31:0] reg_rst [5] = '{user_ctrl_pkg::CTRL_RST,
		user_ctrl_pkg::VOL_CFG_RST, user_ctrl_pkg::BEEP_CFG_RST,
		user_ctrl_pkg::TIMING_RST, 32'h0};
	logic [5:0] step_vol [8] = '{6'h04, 6'h08, 6'h0C, 6'h0C,
		6'h08, 6'h04, 6'h00, 6'h00};
	logic [1:0] step_kind [8] = '{2'h0, 2'h0, 2'h0, 2'h2,
		2'h1, 2'h1, 2'h1, 2'h2};
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	user_switch_program_volume_ctrl #(.DB_1P5_CYC(200), .DB_3P5_CYC(400),
		.DB_5P5_CYC(600), .POR_UNIT_CYC(1), .LONG_UNIT_CYC(1)) u_dut (
		.i_core_clk(clk), .i_reset_n(rst_n),
		.i_program_select_line(sel), .i_second_program_select_line(sel2),
		.i_volume_up_input(up), .i_volume_down_input(down),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
		.i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
		.o_rvalid(rvalid), .i_rready(rready), .o_volume_db(vol),
		.o_memory(mem), .o_mem_change(chg), .o_mem_change_idx(chg_idx),
		.o_beep_req(beep_req), .o_beep_kind(beep_kind), .o_beep_tone(tone),
		.o_beep_level(level), .o_audio_enable(audio_en),
		.o_ms_pull_up(ms_pu), .o_ms2_pull_up(ms2_pu));
	switch_model u_sw (.i_core_clk(clk), .i_ms_pull_up(ms_pu),
		.i_ms2_pull_up(ms2_pu), .o_sel(sel), .o_sel2(sel2), .o_up(up),
		.o_down(down));
	// ************************************************************
	// Beep capture and bus tasks
	// ************************************************************
	// Pulse is a flop output: sample it between edges
	always @(negedge clk) begin
		if (beep_req) begin
			nbeep++;
			last_kind <= beep_kind;
			last_tone <= tone;
			last_level <= level;
		end
	end
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_p, w_p, aw_h, w_h;
		logic [1:0] r;
		aw_p = 1'b1;
		w_p = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= ws;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Handshake values are taken between edges, used at the next
		while (aw_p || w_p) begin
			@(negedge clk);
			aw_h = aw_p && awready;
			w_h = w_p && wready;
			@(posedge clk);
			if (aw_h) begin
				aw_p = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_h) begin
				w_p = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do begin
			@(negedge clk);
			aw_h = bvalid;
			r = bresp;
			@(posedge clk);
		end while (!aw_h);
		bready <= 1'b0;
		chk("write resp", 32'(user_ctrl_pkg::RESP_OKAY), 32'(r));
	endtask
	task automatic rd(input logic [7:0] a);
		logic hit;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			hit = arready;
			@(posedge clk);
		end while (!hit);
		arvalid <= 1'b0;
		do begin
			@(negedge clk);
			hit = rvalid;
			rd_val = rdata;
			rd_resp = rresp;
			@(posedge clk);
		end while (!hit);
		rready <= 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		{wstrb, ws} = 8'hFF;
		rst_n = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 5; k++) begin
			rd(reg_addr[k]);
			chk("reg value", reg_rst[k], rd_val);
			chk("reg resp", (k == 4) ? 32'h2 : 32'h0, 32'(rd_resp));
		end
		chk("memory", 32'(user_ctrl_pkg::MEM_A), 32'(mem));
		chk("volume", 32'(user_ctrl_pkg::VOL_CFG_RST[29:24]), 32'(vol));
		$display("test reset done");
		wr(user_ctrl_pkg::ADDR_BEEP_CFG, 32'h0065_4321);
		wr(user_ctrl_pkg::ADDR_VOL_CFG, 32'h000C_0003);
		wr(user_ctrl_pkg::ADDR_CTRL, 32'h0003_0007);
		for (int k = 0; k < 8; k++) begin
			u_sw.press(k < 4 ? 2 : 3);
			chk("volume", 32'(step_vol[k]), 32'(vol));
			chk("beep kind", 32'(step_kind[k]), 32'(last_kind));
			chk("beep tone", 32'(step_kind[k]) * 2 + 1, 32'(last_tone));
			chk("beep level", 32'(step_kind[k]) * 2 + 2, 32'(last_level));
		end
		chk("beep count", 32'd8, 32'(nbeep));
		wr(user_ctrl_pkg::ADDR_CTRL, 32'h0003_0006);
		u_sw.press(2);
		chk("volume off", 32'h0, 32'(vol));
		chk("beep count", 32'd8, 32'(nbeep));
		wr(user_ctrl_pkg::ADDR_CTRL, 32'h0003_000F);
		u_sw.set(2, 1'b1);
		chk("toggle up", 32'h4, 32'(vol));
		u_sw.set(2, 1'b0);
		chk("toggle down", 32'h0, 32'(vol));
		ws = 4'h4;
		wr(user_ctrl_pkg::ADDR_VOL_CFG, 32'hFF30_FFFF);
		ws = 4'hF;
		rd(user_ctrl_pkg::ADDR_VOL_CFG);
		chk("strobe merge", 32'h0030_0003, rd_val);
		$display("test volume done");
		for (int k = 1; k < 4; k++) begin
			u_sw.press(0);
			chk("memory", 32'(k % 3), 32'(mem));
		end
		wr(user_ctrl_pkg::ADDR_TIMING, 32'h0020_0000);
		wr(user_ctrl_pkg::ADDR_CTRL, 32'h0003_0021);
		u_sw.press(2);
		chk("short press", 32'h4, 32'(vol));
		u_sw.set(2, 1'b1);
		repeat (40) @(posedge clk);
		u_sw.set(2, 1'b0);
		chk("long press", 32'(user_ctrl_pkg::MEM_B), 32'(mem));
		chk("long press vol", 32'h4, 32'(vol));
		$display("test rocker done");
		wr(user_ctrl_pkg::ADDR_CTRL, 32'h0007_1980);
		u_sw.set(1, 1'b1);
		chk("memory", 32'(user_ctrl_pkg::MEM_D), 32'(mem));
		u_sw.set(1, 1'b0);
		repeat (100) @(posedge clk);
		chk("memory", 32'(user_ctrl_pkg::MEM_D), 32'(mem));
		u_sw.set(1, 1'b1);
		u_sw.set(1, 1'b0);
		repeat (150) @(posedge clk);
		chk("memory", 32'(user_ctrl_pkg::MEM_D), 32'(mem));
		repeat (100) @(posedge clk);
		chk("memory", 32'(user_ctrl_pkg::MEM_A), 32'(mem));
		wr(user_ctrl_pkg::ADDR_CTRL, 32'h0007_0980);
		u_sw.set(1, 1'b1);
		u_sw.set(1, 1'b0);
		chk("memory", 32'(user_ctrl_pkg::MEM_A), 32'(mem));
		wr(user_ctrl_pkg::ADDR_CTRL, 32'h0007_0900);
		u_sw.set(1, 1'b1);
		u_sw.press(0);
		chk("memory", 32'(user_ctrl_pkg::MEM_D), 32'(mem));
		u_sw.set(1, 1'b0);
		u_sw.press(0);
		chk("memory", 32'(user_ctrl_pkg::MEM_B), 32'(mem));
		$display("test select done");
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		$display("FAIL watchdog expected done seen hang");
		close_out();
	end
endmodule

// file: sim/user_switch_program_volume_ctrl_chk.sv
`timescale 1ns/1ps
module user_switch_program_volume_ctrl_chk (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic [5:0] o_volume_db,
	input wire logic [2:0] o_memory,
	input wire logic o_mem_change,
	input wire logic [2:0] o_mem_change_idx,
	input wire logic o_beep_req,
	input wire logic [1:0] o_beep_kind,
	input wire logic o_audio_enable
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_reset_n);
	a_vol_range: assert property (o_volume_db <= 6'h30)
		else $error("volume above range");
	a_vol_step: assert property ($changed(o_volume_db) &&
		$past(o_audio_enable) |->
		({1'b0, o_volume_db} <= {1'b0, $past(o_volume_db)} + 7'h04) &&
		({1'b0, $past(o_volume_db)} <= {1'b0, o_volume_db} + 7'h04))
		else $error("volume step too large");
	a_limit_stable: assert property (o_beep_req && o_beep_kind == 2'h2
		|-> $stable(o_volume_db))
		else $error("volume moved on limit beep");
	a_kind_legal: assert property (o_beep_req |-> o_beep_kind != 2'h3)
		else $error("beep kind illegal");
	a_beep_pulse: assert property (o_beep_req |=> !o_beep_req)
		else $error("beep request longer than one cycle");
	a_chg_pulse: assert property (o_mem_change |=> !o_mem_change)
		else $error("memory change longer than one cycle");
	a_chg_idx: assert property (o_mem_change
		|-> o_mem_change_idx == o_memory &&
		(o_memory != $past(o_memory) || $past(i_reset_n, 2) == 1'b0))
		else $error("memory change without a new memory");
	a_mem_trace: assert property ($changed(o_memory)
		|-> o_mem_change || $past(o_mem_change))
		else $error("memory changed without request");
	a_mem_range: assert property (o_memory < 3'h6)
		else $error("memory index out of range");
	a_audio_stays: assert property (o_audio_enable |=> o_audio_enable)
		else $error("audio enable dropped");
	c_limit: cover property (o_beep_req && o_beep_kind == 2'h2);
	c_down: cover property (o_beep_req && o_beep_kind == 2'h1);
	c_mem_d: cover property (o_mem_change && o_mem_change_idx == 3'h3);
endmodule
bind user_switch_program_volume_ctrl user_switch_program_volume_ctrl_chk u_chk (
	.i_core_clk,
	.i_reset_n,
	.o_volume_db,
	.o_memory,
	.o_mem_change,
	.o_mem_change_idx,
	.o_beep_req,
	.o_beep_kind,
	.o_audio_enable
);
